// >>> pkg/psc_pkg.sv
package psc_pkg;
    // ==========================================
    // clock and timing
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned CLK_NS = 1000 / CLK_MHZ;
    localparam int unsigned T_CF2CD_MAX_NS = 600;
    localparam int unsigned T_STATUS_MIN_US = 268;
    localparam int unsigned T_STATUS_MAX_US = 1506;
    localparam int unsigned STATUS_CYC = T_STATUS_MIN_US * CLK_MHZ;
    localparam int unsigned T_POR_US = T_STATUS_MIN_US;
    localparam int unsigned POR_CYC = T_POR_US * CLK_MHZ;
    localparam int unsigned T_CD2UM_MIN_US = 175;
    localparam int unsigned T_CD2UM_MAX_US = 437;
    localparam int unsigned OSC_INIT_CYC = T_CD2UM_MIN_US * CLK_MHZ;
    localparam int unsigned CONFIG_SERIAL_CLOCK_FMAX_MHZ = 125;
    localparam int unsigned CONFIG_SERIAL_CLOCK_TMAX_NS = 1000 / CONFIG_SERIAL_CLOCK_FMAX_MHZ;
    localparam int unsigned CD2CU_NS = 4 * CONFIG_SERIAL_CLOCK_TMAX_NS;
    localparam int unsigned CD2CU_CYC = (CD2CU_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned USR_INIT_CYC = 8576;
    localparam int unsigned DONE_EDGES = 2;
    // ==========================================
    // image layout
    localparam int unsigned IMAGE_BITS_DEF = 1024;
    localparam int unsigned OPT_W = 2;
    localparam int unsigned OPT_USRCLK = 0;
    localparam int unsigned OPT_INITPIN = 1;
    localparam int unsigned CNT_W = 32;
    // ==========================================
    // states
    typedef enum logic [3:0] {
        ST_POR,
        ST_RESET,
        ST_HOLD,
        ST_RELEASE,
        ST_LOAD,
        ST_EDGES,
        ST_INIT_OSC,
        ST_CU_DLY,
        ST_INIT_USR,
        ST_USER
    } psc_state_e;
endpackage

// >>> design/psc_config_port.sv
`timescale 1ns/1ps
// Operation
// - request low restarts configuration
// - user mode: all three lines high
// - status held low for power-on delay
// - load-complete low until configured
// - load-complete released after last bit
// - data pin becomes user pin afterwards
// - init-done pin low until initialized
// - load-complete low within 600 ns
// - status low within 600 ns
// - status low 268 to 1506 us
// - status released within 1506 us
// - data captured on rising clock
// - oscillator init 175 to 437 us
// - user clock: delay plus 8576 periods
// - minimum init cycles for any source
module psc_config_port #(
    parameter int unsigned IMAGE_BITS = psc_pkg::IMAGE_BITS_DEF,
    parameter int unsigned POR_CYC = psc_pkg::POR_CYC,
    parameter int unsigned STATUS_CYC = psc_pkg::STATUS_CYC,
    parameter int unsigned OSC_INIT_CYC = psc_pkg::OSC_INIT_CYC,
    parameter int unsigned USR_INIT_CYC = psc_pkg::USR_INIT_CYC
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_config_request_n,
    input wire logic i_config_serial_clock,
    input wire logic i_serial_config_data,
    input wire logic i_config_status_n,
    input wire logic i_user_init_clock,
    output logic o_config_status_n_out,
    output logic o_config_status_n_oe,
    output logic o_load_complete_out,
    output logic o_load_complete_oe,
    output logic o_init_complete_out,
    output logic o_init_complete_oe,
    output logic o_user_mode,
    output logic o_user_pin,
    output logic o_config_bit,
    output logic o_config_bit_valid
);
    // ==========================================
    // state
    typedef struct packed {
        psc_pkg::psc_state_e st;
        logic config_serial_clock_d;
        logic usr_d;
        logic [psc_pkg::CNT_W-1:0] cnt;
        logic [psc_pkg::CNT_W-1:0] bits;
        logic [psc_pkg::OPT_W-1:0] opt;
        logic status_low;
        logic done;
        logic init_low;
        logic user;
        logic user_pin;
        logic bit_val;
        logic bit_v;
    } psc_reg_s;

    localparam psc_reg_s PSC_RST = '{
        st: psc_pkg::ST_POR,
        config_serial_clock_d: 1'b0,
        usr_d: 1'b0,
        cnt: '0,
        bits: '0,
        opt: '0,
        status_low: 1'b1,
        done: 1'b0,
        init_low: 1'b0,
        user: 1'b0,
        user_pin: 1'b0,
        bit_val: 1'b0,
        bit_v: 1'b0
    };

    psc_reg_s r_reg;
    psc_reg_s r_next;
    logic req_sync;
    logic config_serial_clock_sync;
    logic data_sync;
    logic stat_sync;
    logic usr_sync;
    logic config_serial_clock_rise;
    logic config_serial_clock_fall;
    logic usr_rise;
    logic req_low;

    // ==========================================
    // pin synchronisers
    psc_sync #(
        .RESET_VAL(1'b1)
    ) u_sync_req (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_pin(i_config_request_n),
        .o_level(req_sync)
    );
    psc_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_config_serial_clock (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_pin(i_config_serial_clock),
        .o_level(config_serial_clock_sync)
    );
    psc_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_data (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_pin(i_serial_config_data),
        .o_level(data_sync)
    );
    psc_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_stat (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_pin(i_config_status_n),
        .o_level(stat_sync)
    );
    psc_sync #(
        .RESET_VAL(1'b0)
    ) u_sync_usr (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_pin(i_user_init_clock),
        .o_level(usr_sync)
    );

    // ==========================================
    // edge detection on synchronised pins
    assign config_serial_clock_rise = config_serial_clock_sync & ~r_reg.config_serial_clock_d;
    assign config_serial_clock_fall = ~config_serial_clock_sync & r_reg.config_serial_clock_d;
    assign usr_rise = usr_sync & ~r_reg.usr_d;
    assign req_low = ~req_sync;

    // ==========================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.config_serial_clock_d = config_serial_clock_sync;
        r_next.usr_d = usr_sync;
        r_next.bit_v = 1'b0;
        case (r_reg.st)
            psc_pkg::ST_POR: begin
                // hold status low through the power-on delay
                r_next.status_low = 1'b1;
                r_next.done = 1'b0;
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt >= POR_CYC - 1) begin
                    r_next.cnt = '0;
                    r_next.st = psc_pkg::ST_HOLD;
                end
            end
            psc_pkg::ST_RESET: begin
                r_next.status_low = 1'b1;
                r_next.done = 1'b0;
                r_next.init_low = 1'b0;
                r_next.user = 1'b0;
                r_next.user_pin = 1'b0;
                r_next.bits = '0;
                r_next.opt = '0;
                r_next.cnt = '0;
                if (!req_low) begin
                    r_next.st = psc_pkg::ST_HOLD;
                end
            end
            psc_pkg::ST_HOLD: begin
                // least status low time, counted from request rising or from the end of the power-on delay
                r_next.status_low = 1'b1;
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt >= STATUS_CYC - 1) begin
                    r_next.cnt = '0;
                    r_next.status_low = 1'b0;
                    r_next.st = psc_pkg::ST_RELEASE;
                end
            end
            psc_pkg::ST_RELEASE: begin
                // wait while the host keeps status low externally
                if (stat_sync) begin
                    r_next.st = psc_pkg::ST_LOAD;
                end
            end
            psc_pkg::ST_LOAD: begin
                if (config_serial_clock_rise) begin
                    // one bit per rising serial clock edge
                    r_next.bit_val = data_sync;
                    r_next.bit_v = 1'b1;
                    if (r_reg.bits < psc_pkg::OPT_W) begin
                        r_next.opt[r_reg.bits[0]] = data_sync;
                    end
                    r_next.bits = r_reg.bits + 1'b1;
                    if (r_reg.bits >= IMAGE_BITS - 1) begin
                        r_next.done = 1'b1;
                        r_next.cnt = '0;
                        r_next.st = psc_pkg::ST_EDGES;
                    end
                end
                if (r_reg.bits >= psc_pkg::OPT_W &&
                    r_reg.opt[psc_pkg::OPT_INITPIN]) begin
                    r_next.init_low = 1'b1;
                end
            end
            psc_pkg::ST_EDGES: begin
                // extra falling edges before initialization
                if (config_serial_clock_fall) begin
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (r_reg.cnt >= psc_pkg::DONE_EDGES - 1) begin
                        r_next.cnt = '0;
                        if (r_reg.opt[psc_pkg::OPT_USRCLK]) begin
                            r_next.st = psc_pkg::ST_CU_DLY;
                        end else begin
                            r_next.st = psc_pkg::ST_INIT_OSC;
                        end
                    end
                end
            end
            psc_pkg::ST_INIT_OSC: begin
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt >= OSC_INIT_CYC - 1) begin
                    r_next.st = psc_pkg::ST_USER;
                end
            end
            psc_pkg::ST_CU_DLY: begin
                // user clock edges ignored before the enable delay
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt >= psc_pkg::CD2CU_CYC - 1) begin
                    r_next.cnt = '0;
                    r_next.st = psc_pkg::ST_INIT_USR;
                end
            end
            psc_pkg::ST_INIT_USR: begin
                if (usr_rise) begin
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (r_reg.cnt >= USR_INIT_CYC - 1) begin
                        r_next.st = psc_pkg::ST_USER;
                    end
                end
            end
            psc_pkg::ST_USER: begin
                // all lines released, data pin handed to the user
                r_next.user = 1'b1;
                r_next.init_low = 1'b0;
                r_next.status_low = 1'b0;
                r_next.user_pin = data_sync;
            end
            default: begin
                r_next.st = psc_pkg::ST_RESET;
            end
        endcase
        // request low aborts anything after power-on
        if (req_low && r_reg.st != psc_pkg::ST_POR) begin
            r_next.st = psc_pkg::ST_RESET;
            r_next.status_low = 1'b1;
            r_next.done = 1'b0;
            r_next.user = 1'b0;
            r_next.user_pin = 1'b0;
            r_next.init_low = 1'b0;
            r_next.cnt = '0;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_reg <= PSC_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================
    // open-drain pins and outputs
    assign o_config_status_n_out = 1'b0;
    assign o_config_status_n_oe = r_reg.status_low;
    assign o_load_complete_out = 1'b0;
    assign o_load_complete_oe = ~r_reg.done;
    assign o_init_complete_out = 1'b0;
    assign o_init_complete_oe = r_reg.init_low;
    assign o_user_mode = r_reg.user;
    assign o_user_pin = r_reg.user_pin;
    assign o_config_bit = r_reg.bit_val;
    assign o_config_bit_valid = r_reg.bit_v;
endmodule

// ==========================================
// two-stage synchroniser for one pin
module psc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed {
        logic [1:0] stage;
    } psc_sync_s;

    psc_sync_s s_reg;
    psc_sync_s s_next;

    always_comb begin
        s_next = s_reg;
        s_next.stage = {s_reg.stage[0], i_pin};
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s_reg <= '{stage: {2{RESET_VAL}}};
        end else begin
            s_reg <= s_next;
        end
    end

    // only the second stage is read outside
    assign o_level = s_reg.stage[1];
endmodule

// >>> verification/psc_props.sv
`timescale 1ns/1ps
module psc_props #(
    parameter int STATUS_CYC = 20,
    parameter int OSC_INIT_CYC = 20
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_config_request_n,
    input wire logic i_serial_config_data,
    input wire logic o_config_status_n_oe,
    input wire logic o_load_complete_oe,
    input wire logic o_init_complete_oe,
    input wire logic o_user_mode,
    input wire logic o_user_pin,
    input wire logic o_config_bit,
    input wire logic o_config_bit_valid
);
    localparam int REL_MAX = STATUS_CYC + 8;
    logic [7:0] wait_reg;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // ==========================================
    // cycles since load-complete release
    always_ff @(posedge i_clock) begin
        if (o_load_complete_oe)
            wait_reg <= 8'h00;
        else if (wait_reg != 8'hff)
            wait_reg <= wait_reg + 8'h01;
    end
    // ==========================================
    // properties
    chk_por_hold: assert property (
        $fell(i_reset) |-> o_config_status_n_oe [*8]) else $error("por");
    chk_status_fall: assert property (
        $fell(i_config_request_n) |-> ##[1:30] o_config_status_n_oe)
        else $error("status fall late");
    chk_load_fall: assert property (
        $fell(i_config_request_n) |-> ##[1:30] o_load_complete_oe)
        else $error("load fall late");
    chk_status_hold: assert property (
        $rose(i_config_request_n) && o_config_status_n_oe
        |-> o_config_status_n_oe [*8]) else $error("status short");
    chk_status_rel: assert property (
        $rose(i_config_request_n) |-> ##[1:REL_MAX] !o_config_status_n_oe)
        else $error("status stuck");
    chk_user_lines: assert property (
        o_user_mode |-> !o_config_status_n_oe && !o_load_complete_oe
        && !o_init_complete_oe) else $error("user lines");
    chk_bit_data: assert property (
        o_config_bit_valid |-> o_config_bit == $past(i_serial_config_data, 2))
        else $error("bit value");
    chk_bit_pulse: assert property (
        o_config_bit_valid |=> !o_config_bit_valid) else $error("pulse");
    chk_load_rel: assert property (
        $fell(o_load_complete_oe) |-> o_config_bit_valid)
        else $error("load early");
    chk_init_min: assert property (
        $rose(o_user_mode) |-> wait_reg >= OSC_INIT_CYC)
        else $error("init short");
    chk_pin_idle: assert property (
        !o_user_mode |-> !o_user_pin) else $error("user pin");
endmodule

// >>> verification/psc_host.sv
`timescale 1ns/1ps
module psc_host (
    input wire logic i_clock,
    input wire logic i_status_w,
    output logic o_request_n = 1'b1,
    output logic o_sclk = 1'b0,
    output logic o_data = 1'b0,
    output logic o_uclk = 1'b0
);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic restart();
        int k;
        tick(1);
        o_request_n <= 1'b0;
        tick(100);
        o_request_n <= 1'b1;
        k = 0;
        tick(2);
        while (i_status_w !== 1'b1 && k < 3000) begin
            tick(1);
            k++;
        end
        tick(100);
    endtask
    task automatic sclk_cycle(input logic d);
        o_data <= d;
        tick(4);
        o_sclk <= 1'b1;
        tick(4);
        o_sclk <= 1'b0;
    endtask
    task automatic send(input logic [15:0] img, input int lo, input int hi);
        for (int i = lo; i <= hi; i++)
            sclk_cycle(img[i]);
    endtask
    task automatic uclk_pulses(input int n);
        repeat (n) begin
            tick(4);
            o_uclk <= 1'b1;
            tick(4);
            o_uclk <= 1'b0;
        end
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
$display("CHECK FAILED %s exp=%h got=%h", n, e, g); end end
module tb_top;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    int errors = 0;
    int cmp_count = 0;
    int n_bits = 0;
    int nb0 = 0;
    logic [15:0] got_reg = 16'h0000;
    logic [15:0] img_tab [4] = '{16'h3a50, 16'h5c91, 16'hc3a6, 16'h0ff3};
    logic init_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    wire req_n, sclk, sdat, uclk, st_o, st_oe, ld_oe, in_oe, um, upin;
    wire cbit, cval;
    wire ld_o, in_o;
    wire ld_w = ld_oe ? ld_o : 1'b1;
    wire in_w = in_oe ? in_o : 1'b1;
    wire st_w = st_oe ? st_o : 1'b1;
    always #10 i_clock = ~i_clock;
    psc_host host (.i_clock(i_clock), .i_status_w(st_w), .o_request_n(req_n),
        .o_sclk(sclk), .o_data(sdat), .o_uclk(uclk));
    psc_config_port #(.IMAGE_BITS(16), .POR_CYC(20), .STATUS_CYC(20),
        .OSC_INIT_CYC(20), .USR_INIT_CYC(16)) uut (
        .i_clock(i_clock), .i_reset(i_reset), .i_config_request_n(req_n),
        .i_config_serial_clock(sclk), .i_serial_config_data(sdat),
        .i_config_status_n(st_w), .i_user_init_clock(uclk),
        .o_config_status_n_out(st_o), .o_config_status_n_oe(st_oe),
        .o_load_complete_out(ld_o), .o_load_complete_oe(ld_oe),
        .o_init_complete_out(in_o), .o_init_complete_oe(in_oe),
        .o_user_mode(um), .o_user_pin(upin), .o_config_bit(cbit),
        .o_config_bit_valid(cval));
    always @(posedge i_clock) begin
        if (cval === 1'b1) begin
            got_reg[n_bits[3:0]] <= cbit;
            n_bits <= n_bits + 1;
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clock);
        errors++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        host.tick(5);
        `CHK("por_status", 1'b1, st_oe)
        `CHK("por_load", 1'b1, ld_oe)
        `CHK("por_load_wire", 1'b0, ld_w)
        for (int r = 0; r < 4; r++) begin
            host.restart();
            nb0 = n_bits;
            host.send(img_tab[r], 0, 14);
            host.tick(2);
            `CHK("load_early", 1'b1, ld_oe)
            host.send(img_tab[r], 15, 15);
            host.tick(2);
            `CHK("bits", img_tab[r], got_reg)
            `CHK("count", 16, n_bits - nb0)
            `CHK("load_done", 1'b0, ld_oe)
            `CHK("init_pin", init_tab[r], in_oe)
            `CHK("init_wire", ~init_tab[r], in_w)
            `CHK("load_wire", 1'b1, ld_w)
            host.sclk_cycle(~img_tab[r][15]);
            host.sclk_cycle(~img_tab[r][15]);
            if (img_tab[r][0]) begin
                host.tick(4);
                host.uclk_pulses(15);
                host.tick(8);
                `CHK("usr_early", 1'b0, um)
                host.uclk_pulses(1);
                host.tick(8);
            end else begin
                for (int k = 0; k < 60 && um !== 1'b1; k++)
                    host.tick(1);
            end
            `CHK("user_mode", 1'b1, um)
            `CHK("user_status", 1'b1, st_w)
            `CHK("user_init", 1'b0, in_oe)
            `CHK("user_load", 1'b1, ld_w)
            `CHK("user_init_wire", 1'b1, in_w)
            `CHK("user_pin", ~img_tab[r][15], upin)
            $display("row %0d done", r);
        end
        host.o_request_n <= 1'b0;
        host.tick(5);
        `CHK("abort_status", 1'b1, st_oe)
        `CHK("abort_load", 1'b1, ld_oe)
        `CHK("abort_user", 1'b0, um)
        host.restart();
        host.send(16'h00ff, 0, 9);
        host.tick(60);
        `CHK("partial_load", 1'b1, ld_oe)
        `CHK("partial_user", 1'b0, um)
        $display("abort done");
        test_done();
    end
endmodule
bind psc_config_port psc_props #(
    .STATUS_CYC(STATUS_CYC),
    .OSC_INIT_CYC(OSC_INIT_CYC)
) u_chk (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_config_request_n(i_config_request_n),
    .i_serial_config_data(i_serial_config_data),
    .o_config_status_n_oe(o_config_status_n_oe),
    .o_load_complete_oe(o_load_complete_oe),
    .o_init_complete_oe(o_init_complete_oe),
    .o_user_mode(o_user_mode),
    .o_user_pin(o_user_pin),
    .o_config_bit(o_config_bit),
    .o_config_bit_valid(o_config_bit_valid)
);
